// ===== hw/cst_channel_status.sv
// top: channel pair mux enables, channel status word, measure signal routing, axi4-lite slave
//
// Overview of operation
// - muxen bit 0 set folds channel 1 onto channel 0; resets to zero.
// - muxen bit 1 set folds channel 3 onto channel 2; resets zero.
// - status bits 15..12 are OR of each channel's accumulated fail bits.
// - status bits 11..8 are OR of each channel's timing error flags.
// - odd status bits 7,5,3,1 show live high comparator of channels 3..0.
// - even status bits 6,4,2,0 show live low comparator of channels 3..0.
// - arm, start and stop each select any channel's high or low comparator.
// - each of arm, start and stop can be tristated by its enable.
// - select code: even is channel high, odd is channel low, channel=code/2.
// - enable zero puts the output high impedance; enables reset to zero.
// - writing one to fail clear bit gives one clear pulse; zero does nothing.
`timescale 1ns/1ps
module cst_channel_status
   import cst_pkg::*;
#(
   parameter int NUM_CH  = 4,
   parameter int AFR_W   = 32,
   parameter int TERR_W  = 4
) (
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      resetn,
   // axi4-lite write address
   input  wire logic [CST_ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // axi4-lite read
   input  wire logic [CST_ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // per-channel condition inputs
   input  wire logic [NUM_CH*AFR_W-1:0]   accumulated_fail_registers,
   input  wire logic [NUM_CH*TERR_W-1:0]  timing_error_flags,
   input  wire logic [NUM_CH-1:0]         comp_high,
   input  wire logic [NUM_CH-1:0]         comp_low,
   // formatter controls
   output logic                           pair0_mux_en,
   output logic                           pair1_mux_en,
   output logic                           afr_clear_pulse,
   // measure outputs (oe_n low while driving)
   output logic                           measure_arm_out,
   output logic                           measure_arm_oe_n,
   output logic                           measure_start_out,
   output logic                           measure_start_oe_n,
   output logic                           measure_stop_out,
   output logic                           measure_stop_oe_n,
   // interrupt
   output logic                           irq
);
   // the status word and select codes are laid out for exactly four channels
   if (NUM_CH != 4) begin : g_bad_ch
      $error("cst_channel_status: NUM_CH must be 4");
   end
   if (AFR_W < 1 || TERR_W < 1) begin : g_bad_w
      $error("cst_channel_status: widths must be positive");
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status word
   logic [NUM_CH-1:0] ch_fail;
   logic [NUM_CH-1:0] ch_terr;
   logic [15:0]       status_word;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         assign ch_fail[gi] = |accumulated_fail_registers[gi*AFR_W +: AFR_W];
         assign ch_terr[gi] = |timing_error_flags[gi*TERR_W +: TERR_W];
         assign status_word[CST_FAIL_LSB+gi] = ch_fail[gi];
         assign status_word[CST_TERR_LSB+gi] = ch_terr[gi];
         assign status_word[2*gi+1] = comp_high[gi];
         assign status_word[2*gi]   = comp_low[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // registers
   cst_msel_t   msel_r;
   logic [1:0]  muxen_r;
   logic [7:0]  irq_stat_r;
   logic [7:0]  irq_mask_r;
   logic        afr_clr_r;
   logic [7:0]  events;
   logic [7:0]  events_d_r;
   logic [7:0]  event_rise;

   assign pair0_mux_en = muxen_r[0];
   assign pair1_mux_en = muxen_r[1];
   assign afr_clear_pulse = afr_clr_r;

   // events: rising edge of each channel's fail and timing error summary
   assign events     = {ch_terr, ch_fail};
   assign event_rise = events & ~events_d_r;
   assign irq        = |(irq_stat_r & irq_mask_r);

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel: takes address and data in either order
   cst_wr_state_t     wr_state_r;
   logic              aw_got_r;
   logic              w_got_r;
   logic [7:0]        aw_idx_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              wr_fire;
   logic              wr_lo;
   logic              wr_hi;
   logic              wr_hit;
   logic [7:0]        w1c_mask;

   assign s_axi_awready = (wr_state_r == CST_WR_IDLE) && !aw_got_r;
   assign s_axi_wready  = (wr_state_r == CST_WR_IDLE) && !w_got_r;
   assign wr_fire = (wr_state_r == CST_WR_HOLD);
   assign wr_lo   = wstrb_r[0];
   assign wr_hi   = wstrb_r[1];
   assign wr_hit  = (aw_idx_r == CST_IDX_MSEL) || (aw_idx_r == CST_IDX_MUXEN)
                 || (aw_idx_r == CST_IDX_CTRL) || (aw_idx_r == CST_IDX_IRQ_STAT)
                 || (aw_idx_r == CST_IDX_IRQ_MASK);
   assign w1c_mask = (wr_fire && aw_idx_r == CST_IDX_IRQ_STAT && wr_lo)
                   ? wdata_r[7:0] : 8'h00;

   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wr_state_r <= CST_WR_IDLE;
         aw_got_r   <= 1'b0;
         w_got_r    <= 1'b0;
         aw_idx_r   <= 8'h00;
         wdata_r    <= 32'h0000_0000;
         wstrb_r    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= CST_RESP_OKAY;
      end else begin
         case (wr_state_r)
            CST_WR_IDLE: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  aw_got_r <= 1'b1;
                  aw_idx_r <= s_axi_awaddr[CST_ADDR_W-1:2];
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  w_got_r <= 1'b1;
                  wdata_r <= s_axi_wdata;
                  wstrb_r <= s_axi_wstrb;
               end
               if ((aw_got_r || s_axi_awvalid) && (w_got_r || s_axi_wvalid)) begin
                  wr_state_r <= CST_WR_HOLD;
               end
            end
            CST_WR_HOLD: begin
               aw_got_r     <= 1'b0;
               w_got_r      <= 1'b0;
               s_axi_bvalid <= 1'b1;
               s_axi_bresp  <= wr_hit ? CST_RESP_OKAY : CST_RESP_SLVERR;
               wr_state_r   <= CST_WR_RESP;
            end
            CST_WR_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wr_state_r   <= CST_WR_IDLE;
               end
            end
            default: wr_state_r <= CST_WR_IDLE;
         endcase
      end
   end

   // register updates on the commit cycle
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         msel_r     <= CST_MSEL_RST;
         muxen_r    <= CST_MUXEN_RST;
         irq_mask_r <= CST_IRQ_RST;
         afr_clr_r  <= 1'b0;
      end else begin
         if (wr_fire && aw_idx_r == CST_IDX_MSEL) begin
            if (wr_lo) msel_r[7:0]  <= wdata_r[7:0];
            if (wr_hi) msel_r[11:8] <= wdata_r[11:8];
         end
         if (wr_fire && aw_idx_r == CST_IDX_MUXEN && wr_lo) begin
            muxen_r <= wdata_r[1:0];
         end
         if (wr_fire && aw_idx_r == CST_IDX_IRQ_MASK && wr_lo) begin
            irq_mask_r <= wdata_r[7:0];
         end
         // self-clearing: one cycle wide no matter what was written
         afr_clr_r <= wr_fire && aw_idx_r == CST_IDX_CTRL && wr_lo
                      && wdata_r[CST_AFR_CLR_BIT];
      end
   end

   // sticky events: a new edge wins over a write-one-to-clear in the same cycle
   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_stat_r <= CST_IRQ_RST;
         events_d_r <= CST_IRQ_RST;
      end else begin
         events_d_r <= events;
         irq_stat_r <= (irq_stat_r & ~w1c_mask) | event_rise;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // measure routing: code/2 is the channel, code lsb picks low comparator
   function automatic logic pick_comp(input logic [2:0] code, input logic [NUM_CH-1:0] hi,
                                      input logic [NUM_CH-1:0] lo);
      pick_comp = code[0] ? lo[code[2:1]] : hi[code[2:1]];
   endfunction

   // outputs run combinational so comparator edges keep their timing to the unit
   assign measure_arm_out    = pick_comp(msel_r.arm_sel, comp_high, comp_low);
   assign measure_start_out  = pick_comp(msel_r.start_sel, comp_high, comp_low);
   assign measure_stop_out   = pick_comp(msel_r.stop_sel, comp_high, comp_low);
   assign measure_arm_oe_n   = ~msel_r.arm_en;
   assign measure_start_oe_n = ~msel_r.start_en;
   assign measure_stop_oe_n  = ~msel_r.stop_en;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel, one cycle to rvalid
   logic [7:0]  ar_idx;
   logic [31:0] rd_mux;
   logic        rd_hit;
   assign ar_idx = s_axi_araddr[CST_ADDR_W-1:2];
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_hit = (ar_idx >= CST_IDX_MSEL) && (ar_idx <= CST_IDX_IRQ_MASK);
   assign rd_mux =
        (ar_idx == CST_IDX_MSEL)     ? {20'h00000, msel_r}
      : (ar_idx == CST_IDX_MUXEN)    ? {30'h00000000, muxen_r}
      : (ar_idx == CST_IDX_STATUS)   ? {16'h0000, status_word}
      : (ar_idx == CST_IDX_IRQ_STAT) ? {24'h000000, irq_stat_r}
      : (ar_idx == CST_IDX_IRQ_MASK) ? {24'h000000, irq_mask_r}
      : 32'h0000_0000;

   always_ff @(posedge clock or negedge rst_n_r) begin
      if (!rst_n_r) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= CST_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_hit ? CST_RESP_OKAY : CST_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence ctrl_write_s;
      wr_fire && aw_idx_r == CST_IDX_CTRL && wr_lo && wdata_r[CST_AFR_CLR_BIT];
   endsequence

   afr_pulse_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      ctrl_write_s |=> afr_clear_pulse ##1 !afr_clear_pulse)
      else $error("fail clear pulse not a single cycle");
   afr_cause_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      afr_clear_pulse |-> $past(wr_fire) && $past(wdata_r[CST_AFR_CLR_BIT]))
      else $error("fail clear pulse without a write of one");
   pair0_mux_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      (wr_fire && aw_idx_r == CST_IDX_MUXEN && wr_lo) |=> pair0_mux_en == $past(wdata_r[0]))
      else $error("pair0 mux enable not updated");
   pair1_mux_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      $changed(pair1_mux_en) |-> $past(wr_fire) && $past(aw_idx_r) == CST_IDX_MUXEN)
      else $error("pair1 mux enable changed without write");
   fail_sum_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      status_word[15:12] == {|accumulated_fail_registers[3*AFR_W +: AFR_W],
         |accumulated_fail_registers[2*AFR_W +: AFR_W],
         |accumulated_fail_registers[AFR_W +: AFR_W], |accumulated_fail_registers[AFR_W-1:0]})
      else $error("fail summary mismatch");
   terr_sum_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      status_word[11:8] == {|timing_error_flags[3*TERR_W +: TERR_W],
         |timing_error_flags[2*TERR_W +: TERR_W], |timing_error_flags[TERR_W +: TERR_W],
         |timing_error_flags[TERR_W-1:0]})
      else $error("timing error summary mismatch");
   comp_bits_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      status_word[7:0] == {comp_high[3], comp_low[3], comp_high[2], comp_low[2],
         comp_high[1], comp_low[1], comp_high[0], comp_low[0]})
      else $error("comparator bits mismatch");
   comp_low_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      status_word[0] == comp_low[0] && status_word[6] == comp_low[3])
      else $error("comparator bit order wrong");
   start_route_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      !msel_r.start_sel[0] |-> measure_start_out == comp_high[msel_r.start_sel[2:1]])
      else $error("start route wrong");
   stop_route_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      msel_r.stop_sel[0] |-> measure_stop_out == comp_low[msel_r.stop_sel[2:1]])
      else $error("stop route wrong");
   arm_hiz_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      measure_arm_oe_n == !msel_r.arm_en)
      else $error("arm enable not followed");
   start_hiz_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      measure_start_oe_n == !msel_r.start_en)
      else $error("start enable not followed");
   arm_route_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      (msel_r.arm_sel == 3'h7) |-> measure_arm_out == comp_low[3])
      else $error("arm route wrong");
   stop_hiz_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      !msel_r.stop_en |-> measure_stop_oe_n)
      else $error("stop driven while disabled");
   // a rising event must land even when a clear of the same bit is committed
   irq_level_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      |event_rise |=> (irq_stat_r & $past(event_rise)) == $past(event_rise))
      else $error("event lost");

   // write walk: both halves taken, one commit cycle, then the response
   sequence wr_take_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_answer_s;
      wr_fire ##1 s_axi_bvalid;
   endsequence

   wr_walk_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      wr_take_s |=> wr_answer_s)
      else $error("write response out of step");
   rd_walk_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   b_hold_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   r_hold_a: assert property (@(posedge clock) disable iff (!rst_n_r)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule

// ===== hw/cst_pkg.sv
// package: register map, field layout and types for the channel status / measure select block
package cst_pkg;
   // register indices (printed offsets are not multiples of four)
   localparam logic [7:0] CST_IDX_MSEL     = 8'h1c;
   localparam logic [7:0] CST_IDX_MUXEN    = 8'h1d;
   localparam logic [7:0] CST_IDX_STATUS   = 8'h1e;
   localparam logic [7:0] CST_IDX_CHIPINFO = 8'h1f;
   localparam logic [7:0] CST_IDX_CTRL     = 8'h20;
   localparam logic [7:0] CST_IDX_IRQ_STAT = 8'h21;
   localparam logic [7:0] CST_IDX_IRQ_MASK = 8'h22;
   localparam int CST_ADDR_W = 10;
   // measure select field positions
   localparam int CST_ARM_SEL_LSB   = 0;
   localparam int CST_ARM_EN_BIT    = 3;
   localparam int CST_START_SEL_LSB = 4;
   localparam int CST_START_EN_BIT  = 7;
   localparam int CST_STOP_SEL_LSB  = 8;
   localparam int CST_STOP_EN_BIT   = 11;
   // status field positions
   localparam int CST_FAIL_LSB = 12;
   localparam int CST_TERR_LSB = 8;
   // control register bit
   localparam int CST_AFR_CLR_BIT = 2;
   // reset values
   localparam logic [11:0] CST_MSEL_RST  = 12'h000;
   localparam logic [1:0]  CST_MUXEN_RST = 2'h0;
   localparam logic [7:0]  CST_IRQ_RST   = 8'h00;
   // axi responses
   localparam logic [1:0] CST_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CST_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       stop_en;
      logic [2:0] stop_sel;
      logic       start_en;
      logic [2:0] start_sel;
      logic       arm_en;
      logic [2:0] arm_sel;
   } cst_msel_t;

   // two-signal form of a tristatable output
   typedef struct packed {
      logic o;
      logic oe_n;
   } cst_tri_t;

   typedef enum logic [2:0] {
      CST_WR_IDLE = 3'h1,
      CST_WR_RESP = 3'h2,
      CST_WR_HOLD = 3'h4
   } cst_wr_state_t;
endpackage

// ===== verif/cst_tmu_model.sv
// board select logic and measure unit input lines seen by the external time measure unit
`timescale 1ns/1ps
module cst_tmu_model (
   // clock
   input  wire logic       clock,
   // board selection of this device
   input  wire logic       dev_sel,
   // arm, start, stop from the device
   input  wire logic [2:0] o,
   input  wire logic [2:0] oe_n,
   // lines as the unit sees them
   output logic [2:0]      line
);
   logic [2:0] last_r = 3'h0;

   always @(posedge clock) begin
      last_r <= line;
   end

   // a released or unselected line shows no stale copy: it toggles every cycle
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         line[i] = (dev_sel && !oe_n[i]) ? o[i] : ~last_r[i];
      end
   end
endmodule

// ===== verif/test_channel_status_and_tmu_select.sv
// bench: registers, status word, measure routing and interrupts of the channel status block
`timescale 1ns/1ps
module test_channel_status_and_tmu_select
   import cst_pkg::*;
;
   logic                  clock, resetn, dev_sel, irq;
   logic [CST_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]           s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]            s_axi_wstrb, comp_high, comp_low;
   logic [1:0]            s_axi_bresp, s_axi_rresp, resp;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                  s_axi_rvalid, s_axi_rready, pair0_mux_en, pair1_mux_en;
   logic                  afr_clear_pulse;
   logic [127:0]          afr;
   logic [15:0]           terr;
   logic [2:0]            m_o, m_oe_n, m_line;
   int                    n_mismatch, n_checks;
   int                    n_pulse = 0;

   cst_channel_status dut_u (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .accumulated_fail_registers(afr),
      .timing_error_flags(terr), .comp_high, .comp_low, .pair0_mux_en, .pair1_mux_en,
      .afr_clear_pulse, .measure_arm_out(m_o[0]), .measure_arm_oe_n(m_oe_n[0]),
      .measure_start_out(m_o[1]), .measure_start_oe_n(m_oe_n[1]),
      .measure_stop_out(m_o[2]), .measure_stop_oe_n(m_oe_n[2]), .irq);

   cst_tmu_model tmu_u (.clock, .dev_sel, .o(m_o), .oe_n(m_oe_n), .line(m_line));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   always @(posedge clock) begin
      if (afr_clear_pulse === 1'b1) n_pulse <= n_pulse + 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // bready and rready stay high, so only the valids move between transfers
   task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
      bit a, w, done;
      done = 0;
      @(posedge clock);
      s_axi_awaddr  <= {idx, 2'h0};
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (!done) begin
         @(negedge clock);
         a = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         done = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clock);
         if (a) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
   endtask

   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      bit a, done;
      done = 0;
      @(posedge clock);
      s_axi_araddr  <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      while (!done) begin
         @(negedge clock);
         a = s_axi_arvalid && s_axi_arready;
         done = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock);
         if (a) s_axi_arvalid <= 1'b0;
      end
   endtask

   task automatic drive(input bit rnd);
      @(posedge clock);
      for (int c = 0; c < 4; c++) begin
         afr[c*32 +: 32] <= (rnd && $urandom % 2) ? $urandom : 32'h0;
         terr[c*4 +: 4]  <= rnd ? 4'($urandom % 16) : 4'h0;
      end
      comp_high <= 4'($urandom % 16);
      comp_low  <= 4'($urandom % 16);
   endtask

   // reference model of the status word
   function automatic logic [31:0] exp_status();
      logic [31:0] s;
      s = 32'h0;
      for (int c = 0; c < 4; c++) begin
         s[12+c]  = (afr[c*32 +: 32] != 0);
         s[8+c]   = (terr[c*4 +: 4] != 0);
         s[2*c+1] = comp_high[c];
         s[2*c]   = comp_low[c];
      end
      return s;
   endfunction

   function automatic logic pick(input int code);
      int k;
      k = code % 8;
      return (k % 2) ? comp_low[k/2] : comp_high[k/2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      close_out();
   end

   initial begin
      n_mismatch = 0;
      n_checks = 0;
      resetn = 1'b0;
      dev_sel = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      s_axi_arvalid = 1'b0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      afr = '0;
      terr = '0;
      comp_high = 4'h0;
      comp_low = 4'h0;
      void'($urandom(1));
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      #2;
      check(m_oe_n, 3'h7);
      check({pair1_mux_en, pair0_mux_en}, 2'h0);
      check(irq, 1'b0);
      axi_rd(CST_IDX_MSEL, rd, resp);
      check(rd, 32'h0);
      for (int v = 0; v < 4; v++) begin
         axi_wr(CST_IDX_MUXEN, 32'hfffc | v, resp);
         #2;
         check({pair1_mux_en, pair0_mux_en}, v[1:0]);
         axi_rd(CST_IDX_MUXEN, rd, resp);
         check(rd, v);
      end
      axi_wr(CST_IDX_STATUS, 32'hffff, resp);
      for (int i = 0; i < 12; i++) begin
         drive(i < 10);
         axi_rd(CST_IDX_STATUS, rd, resp);
         check(rd, exp_status());
      end
      for (int c = 0; c < 8; c++) begin
         rd = 32'h888 | c | (((c + 3) % 8) << 4) | (((c + 5) % 8) << 8);
         axi_wr(CST_IDX_MSEL, rd, resp);
         for (int k = 0; k < 2; k++) begin
            drive(1);
            #2;
            check(m_oe_n, 3'h0);
            check(m_line, {pick(c + 5), pick(c + 3), pick(c)});
         end
      end
      axi_wr(CST_IDX_MSEL, 32'h800, resp);
      #2;
      check(m_oe_n, 3'h3);
      check(m_line[2], comp_high[0]);
      // low byte lane only: stop half must keep its value
      @(posedge clock);
      s_axi_wstrb <= 4'h1;
      axi_wr(CST_IDX_MSEL, 32'hfff, resp);
      check(resp, CST_RESP_OKAY);
      axi_rd(CST_IDX_MSEL, rd, resp);
      check(rd, 32'h8ff);
      s_axi_wstrb <= 4'hf;
      axi_wr(CST_IDX_CTRL, 32'h4, resp);
      repeat (3) @(posedge clock);
      check(n_pulse, 1);
      axi_wr(CST_IDX_CTRL, 32'h0, resp);
      repeat (3) @(posedge clock);
      check(n_pulse, 1);
      // interrupts: quiet inputs, clear, then one fail and one timing error rise
      drive(0);
      axi_wr(CST_IDX_IRQ_MASK, 32'h0, resp);
      axi_wr(CST_IDX_IRQ_STAT, 32'hff, resp);
      axi_rd(CST_IDX_IRQ_STAT, rd, resp);
      check(rd, 32'h0);
      afr[95:64] <= 32'h10;
      terr[7:4]  <= 4'h2;
      repeat (3) @(posedge clock);
      axi_rd(CST_IDX_IRQ_STAT, rd, resp);
      check(rd, 32'h24);
      check(irq, 1'b0);
      axi_wr(CST_IDX_IRQ_MASK, 32'h4, resp);
      #2;
      check(irq, 1'b1);
      axi_wr(CST_IDX_IRQ_STAT, 32'h4, resp);
      #2;
      check(irq, 1'b0);
      axi_rd(8'h30, rd, resp);
      check(resp, CST_RESP_SLVERR);
      check(rd, 32'h0);
      axi_wr(8'h30, 32'h1, resp);
      check(resp, CST_RESP_SLVERR);
      axi_rd(CST_IDX_CHIPINFO, rd, resp);
      check(resp, CST_RESP_OKAY);
      close_out();
   end
endmodule
